// ===== trc_top.sv
`default_nettype none
// -----------------------------------------------------------------
// TTL and relay control port with a classic Wishbone slave.
// -----------------------------------------------------------------
module trc_top #(
    parameter int NUM_IN = 4,
    parameter int MARK_CYCLES = trc_pkg::MARK_MS * trc_pkg::TICK_CYCLES,
    parameter int TICK_CYCLES = trc_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] ttl_in,
    output logic [1:0] ttl_out,
    output logic [1:0] relay_closed,
    output logic valve_inject,
    output logic zero_pulse,
    output logic pump_run,
    output logic suppressor_run,
    output logic aux_supply_on,
    output logic mark_active,
    output logic [7:0] mark_percent
);
    // -------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------
    // The register layout only has room for four channels.
    if (NUM_IN != 4) begin : g_bad_num
        $error("NUM_IN must be 4.");
    end
    if (MARK_CYCLES < 1 || MARK_CYCLES > 2 ** 24 - 1) begin : g_bad_mark
        $error("MARK_CYCLES out of range.");
    end
    // The divider is 16 bits wide and needs at least two states.
    if (TICK_CYCLES < 2 || TICK_CYCLES > 2 ** 16) begin : g_bad_tick
        $error("TICK_CYCLES out of range.");
    end

    // -------------------------------------------------------------
    // Registers and state
    // -------------------------------------------------------------
    logic [7:0] func_map_ff; // Function code of each input.
    logic [1:0] ctype_ff; // Input control type.
    logic [3:0] out_ff; // TTL outputs in low bits, relays above.
    logic ack_ff; // Bus acknowledge.
    logic [31:0] rdata_ff; // Read data register.
    logic valve_inject_ff; // Injection valve position.
    logic pump_ff; // Pump, suppressor and aux supply.
    logic zero_ff; // Baseline zero strobe.
    logic [23:0] mark_cnt_ff; // Remaining mark cycles.
    logic [15:0] tick_cnt_ff; // Millisecond divider.
    logic tick_ff; // Millisecond enable pulse.
    logic [NUM_IN-1:0] fall_evt;
    logic [NUM_IN-1:0] rise_evt;

    // -------------------------------------------------------------
    // Millisecond tick divider
    // -------------------------------------------------------------
    wire tick_wrap = tick_cnt_ff == 16'(TICK_CYCLES - 1);

    // A one-cycle enable every millisecond paces the input samplers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= tick_wrap ? 16'h0000 : tick_cnt_ff + 16'h0001;
            tick_ff <= tick_wrap;
        end
    end

    // -------------------------------------------------------------
    // Input channels
    // -------------------------------------------------------------
    // Each channel is independent and shares only the tick and type.
    for (genvar i = 0; i < NUM_IN; i++) begin : g_chan
        trc_chan u_chan (
            .clk(clk),
            .sys_rst(sys_rst),
            .pin_in(ttl_in[i]),
            .tick_ms(tick_ff),
            .ctype(ctype_ff),
            .fall_evt(fall_evt[i]),
            .rise_evt(rise_evt[i])
        );
    end

    // -------------------------------------------------------------
    // Event decode
    // -------------------------------------------------------------
    // Inverted types swap which edge counts as the activating one.
    function automatic trc_pkg::trc_act_type decode(
        input logic [1:0] fn,
        input logic on_evt,
        input logic off_evt
    );
        trc_pkg::trc_act_type a;
        a = '0;
        case (fn)
            trc_pkg::FN_VALVE: begin
                a.valve_load = on_evt;
                a.valve_inject = off_evt;
            end
            trc_pkg::FN_ZERO: begin
                a.zero = on_evt;
            end
            trc_pkg::FN_PUMP: begin
                a.pump_on = on_evt;
                a.pump_off = off_evt;
            end
            default: begin
                a.mark = on_evt;
            end
        endcase
        return a;
    endfunction

    wire inv = ctype_ff[0];
    trc_pkg::trc_act_type act [NUM_IN];
    for (genvar i = 0; i < NUM_IN; i++) begin : g_dec
        assign act[i] = decode(func_map_ff[2*i +: 2],
            inv ? rise_evt[i] : fall_evt[i],
            inv ? fall_evt[i] : rise_evt[i]);
    end
    trc_pkg::trc_act_type act_any;
    assign act_any = act[0] | act[1] | act[2] | act[3];

    // -------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------
    wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wr = req & wb_we_i;
    wire wr_cfg = wr & (wb_adr_i == trc_pkg::ADDR_CONFIG);
    wire wr_out = wr & (wb_adr_i == trc_pkg::ADDR_OUTPUT) & wb_sel_i[0];
    wire wr_cmd = wr & (wb_adr_i == trc_pkg::ADDR_CMD) & wb_sel_i[0];
    // Command word bits: 0 load, 1 inject, 2 zero, 3 pump on,
    // 4 pump off, 5 mark.
    wire [5:0] cmd = wr_cmd ? wb_dat_i[5:0] : 6'h00;
    wire do_load = act_any.valve_load | cmd[0];
    wire do_inject = act_any.valve_inject | cmd[1];
    wire do_zero = act_any.zero | cmd[2];
    wire do_pump_on = act_any.pump_on | cmd[3];
    wire do_pump_off = act_any.pump_off | cmd[4];
    wire do_mark = act_any.mark | cmd[5];
    wire [31:0] status_word = {24'h000000, 2'b00, ctype_ff,
        mark_active, zero_ff, pump_ff, valve_inject_ff};
    wire [31:0] rd_mux =
        (wb_adr_i == trc_pkg::ADDR_CONFIG) ?
            {22'h000000, ctype_ff, func_map_ff} :
        (wb_adr_i == trc_pkg::ADDR_OUTPUT) ? {28'h0000000, out_ff} :
        (wb_adr_i == trc_pkg::ADDR_STATUS) ? status_word :
        32'h00000000; // Unmapped addresses read zero.

    // Acknowledge every request one cycle after it appears.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            ack_ff <= req;
            if (req) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // Configuration register, reset to the default map and edge type.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            func_map_ff <= trc_pkg::FUNC_MAP_RESET;
            ctype_ff <= trc_pkg::CT_NORM_EDGE;
        end else if (wr_cfg) begin
            if (wb_sel_i[0]) begin
                func_map_ff <= wb_dat_i[trc_pkg::CFG_FUNC_POS +: 8];
            end
            if (wb_sel_i[1]) begin
                ctype_ff <= wb_dat_i[trc_pkg::CFG_TYPE_POS +: 2];
            end
        end
    end

    // Output states follow host writes only.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_ff <= trc_pkg::OUT_RESET;
        end else if (wr_out) begin
            out_ff <= wb_dat_i[3:0];
        end
    end

    // -------------------------------------------------------------
    // Instrument actions
    // -------------------------------------------------------------
    // Load wins if both arrive together, leaving the valve safe.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valve_inject_ff <= 1'b0;
            pump_ff <= 1'b0;
            zero_ff <= 1'b0;
        end else begin
            if (do_load) begin
                valve_inject_ff <= 1'b0;
            end else if (do_inject) begin
                valve_inject_ff <= 1'b1;
            end
            if (do_pump_off) begin
                pump_ff <= 1'b0;
            end else if (do_pump_on) begin
                pump_ff <= 1'b1;
            end
            zero_ff <= do_zero;
        end
    end

    // A new mark restarts the half-second window.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mark_cnt_ff <= 24'h000000;
        end else if (do_mark) begin
            mark_cnt_ff <= 24'(MARK_CYCLES);
        end else if (mark_cnt_ff != 24'h000000) begin
            mark_cnt_ff <= mark_cnt_ff - 24'h000001;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign ttl_out = out_ff[1:0];
    assign relay_closed = out_ff[3:2];
    assign valve_inject = valve_inject_ff;
    assign zero_pulse = zero_ff;
    assign pump_run = pump_ff;
    assign suppressor_run = pump_ff;
    assign aux_supply_on = pump_ff;
    assign mark_active = mark_cnt_ff != 24'h000000;
    assign mark_percent = mark_active ? trc_pkg::MARK_PERCENT : 8'h00;
endmodule
`default_nettype wire

// ===== trc_pkg.sv
// Operation
// - Four TTL inputs, two TTL outputs, two relays.
// - Each input assigned one of four functions.
// - Valve function moves only the injection valve.
// - Pump switches suppressor and auxiliary supply too.
// - Mark lasts 0.5 s at tenth full scale.
// - Four control types; normal edge after reset.
// - Normal edge: falling edge activates, valve loads.
// - Rising edge: inject, pump off, else nothing.
// - Inverted edge swaps the two edges.
// - Normal pulse: falling edge active, rising ignored.
// - Accept pulses of 50 ms, reject 4 ms.
// - Inverted pulse swaps active and ignored edges.
// - TTL outputs idle high; low starts action.
// - Relays open by default, close on command.
// - Outputs set by host command or program.
// - Default map: valve, zero, pump, mark.
`default_nettype none
package trc_pkg;
    // -------------------------------------------------------------
    // Bus register map
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h00; // Functions and type.
    localparam logic [7:0] ADDR_OUTPUT = 8'h04; // TTL and relay states.
    localparam logic [7:0] ADDR_STATUS = 8'h08; // Block state.
    localparam logic [7:0] ADDR_CMD = 8'h0c; // Write-one command pulses.
    // Field positions of the configuration word.
    localparam int CFG_FUNC_POS = 0; // Four 2-bit function codes.
    localparam int CFG_TYPE_POS = 8; // 2-bit control type.
    // Reset values.
    localparam logic [7:0] FUNC_MAP_RESET = 8'he4; // Valve,zero,pump,mark.
    localparam logic [3:0] OUT_RESET = 4'h3; // TTL high, relays open.
    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_HZ = 20000000; // System clock rate.
    localparam int TICK_US = 1000; // Millisecond sampling tick.
    localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam int ACCEPT_MS = 50; // Pulses this long always qualify.
    localparam int REJECT_MS = 4; // Pulses this short never qualify.
    localparam int QUALIFY_MS = (ACCEPT_MS + REJECT_MS) / 2 + 1;
    localparam int MARK_MS = 500; // Chart mark length.
    localparam logic [7:0] MARK_PERCENT = 8'h0a; // Mark amplitude in %.
    // Input functions.
    typedef enum logic [1:0] {
        FN_VALVE = 2'h0,
        FN_ZERO = 2'h1,
        FN_PUMP = 2'h2,
        FN_MARK = 2'h3
    } trc_func_type;
    // Control types.
    typedef enum logic [1:0] {
        CT_NORM_EDGE = 2'h0,
        CT_INV_EDGE = 2'h1,
        CT_NORM_PULSE = 2'h2,
        CT_INV_PULSE = 2'h3
    } trc_ctype_type;
    // Action bundle produced by the decoder.
    typedef struct packed {
        logic valve_load;
        logic valve_inject;
        logic zero;
        logic pump_on;
        logic pump_off;
        logic mark;
    } trc_act_type;
endpackage
`default_nettype wire

// ===== trc_chan.sv
`default_nettype none
// -----------------------------------------------------------------
// One TTL input channel: synchroniser, edge and pulse qualifier.
// -----------------------------------------------------------------
module trc_chan (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin_in,
    input wire logic tick_ms,
    input wire logic [1:0] ctype,
    output logic fall_evt,
    output logic rise_evt
);
    logic sync1_ff; // First stage, read only by the second.
    logic sync2_ff; // Synchronised level.
    logic lvl_ff; // Level seen on the previous tick.
    logic [6:0] wid_ff; // Width of the current level in ms.
    logic pulse_ok_ff; // Current pulse already long enough.
    logic fall_ff;
    logic rise_ff;
    wire pulse_mode = ctype[1];
    wire active_low = ~ctype[0]; // Normal pulse: low is the active part.
    wire chg = tick_ms & (sync2_ff != lvl_ff);
    wire in_active = (lvl_ff == ~active_low);
    wire long_enough = wid_ff >= 7'(trc_pkg::QUALIFY_MS);
    // The active level has just lasted long enough, reported once only.
    wire qualified = tick_ms & ~chg & long_enough & in_active
        & ~pulse_ok_ff;

    // Two flops bring the pin onto clk before any logic reads it.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    // Sample on the tick and measure how long each level lasts.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lvl_ff <= 1'b1;
            wid_ff <= 7'h00;
            pulse_ok_ff <= 1'b0;
        end else if (tick_ms) begin
            lvl_ff <= sync2_ff;
            if (chg) begin
                wid_ff <= 7'h00;
                pulse_ok_ff <= 1'b0;
            end else if (!long_enough) begin
                wid_ff <= wid_ff + 7'h01;
            end else if (in_active) begin
                pulse_ok_ff <= 1'b1;
            end
        end
    end

    // In pulse modes the event fires once the active level has lasted
    // past the threshold midway between 4 ms and 50 ms; in edge modes
    // each sampled transition fires at once.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fall_ff <= 1'b0;
            rise_ff <= 1'b0;
        end else if (pulse_mode) begin
            // An inverted pulse reports on the rise line, because the
            // top swaps the two lines for every inverted type.
            fall_ff <= qualified & active_low;
            rise_ff <= qualified & ~active_low;
        end else begin
            fall_ff <= chg & lvl_ff;
            rise_ff <= chg & ~lvl_ff;
        end
    end

    assign fall_evt = fall_ff;
    assign rise_evt = rise_ff;
endmodule
`default_nettype wire

// ===== trc_top_asserts.sv
`default_nettype none
// Watches the port of the TTL and relay control block.
module trc_top_asserts #(
    parameter int MARK_CYCLES = 50
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic [1:0] ttl_out,
    input wire logic [1:0] relay_closed,
    input wire logic valve_inject,
    input wire logic zero_pulse,
    input wire logic pump_run,
    input wire logic suppressor_run,
    input wire logic aux_supply_on,
    input wire logic mark_active,
    input wire logic [7:0] mark_percent
);
    // Length of the present mark, so its end can be judged.
    logic [31:0] mark_run_ff;
    logic [31:0] nxt_mark_run;
    assign nxt_mark_run = mark_active ? mark_run_ff + 32'h1 : 32'h0;
    always_ff @(posedge clk) begin
        mark_run_ff <= sys_rst ? 32'h0 : nxt_mark_run;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held longer than one cycle");
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("bus request not answered in one cycle");
    property p_reset;
        $fell(sys_rst) |-> ttl_out == 2'h3 && relay_closed == 2'h0
            && !valve_inject && !pump_run && !mark_active;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not at idle after reset");
    property p_supply;
        suppressor_run == pump_run && aux_supply_on == pump_run;
    endproperty
    a_supply: assert property (p_supply)
        else $error("suppressor or supply differs from pump");
    property p_mark_pct;
        mark_percent == (mark_active ? 8'h0a : 8'h00);
    endproperty
    a_mark_pct: assert property (p_mark_pct)
        else $error("mark amplitude wrong");
    property p_mark_len;
        $fell(mark_active) |-> mark_run_ff >= MARK_CYCLES;
    endproperty
    a_mark_len: assert property (p_mark_len)
        else $error("mark ended too early");
    property p_out_cause;
        ($changed(ttl_out) || $changed(relay_closed)) && !$past(sys_rst)
            |-> $past(wb_we_i && wb_adr_i == trc_pkg::ADDR_OUTPUT);
    endproperty
    a_out_cause: assert property (p_out_cause)
        else $error("output changed without a host write");
    property p_zero_once;
        zero_pulse |=> !zero_pulse;
    endproperty
    a_zero_once: assert property (p_zero_once)
        else $error("zero pulse longer than one cycle");
endmodule
bind trc_top trc_top_asserts #(.MARK_CYCLES(MARK_CYCLES)) i_chk (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o), .ttl_out(ttl_out), .relay_closed(relay_closed),
    .valve_inject(valve_inject), .zero_pulse(zero_pulse),
    .pump_run(pump_run), .suppressor_run(suppressor_run),
    .aux_supply_on(aux_supply_on), .mark_active(mark_active),
    .mark_percent(mark_percent));
`default_nettype wire

// ===== trc_ctrl_model.sv
`default_nettype none
// External controller: drives the four input lines, obeys the outputs.
module trc_ctrl_model (
    input wire logic clk,
    input wire logic [3:0] level_req,
    input wire logic [1:0] ttl_out,
    output logic [3:0] ttl_in,
    output logic [1:0] action_on
);
    timeunit 1ns;
    timeprecision 1ns;
    // Lines idle high and change only on an edge, each level held whole.
    initial ttl_in = 4'hf;
    always @(posedge clk) begin
        ttl_in <= level_req;
    end
    // A low output starts this device's action.
    assign action_on = ~ttl_out;
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MARK_N = 50;
    // A scaled millisecond keeps the pulse tests short.
    localparam int TICK_N = 20;
    logic clk, sys_rst, cyc, stb, we, ack;
    logic inject, zero, pump, supp, aux, mark;
    logic [7:0] adr, pct, m8;
    logic [31:0] dat, rdat;
    logic [3:0] sel, lvl, ttl_in, r;
    logic [1:0] ttl_out, relay, act;
    logic [31:0] exp_q[$];
    int errors, comparisons, zero_n, mark_n;
    trc_top #(.MARK_CYCLES(MARK_N), .TICK_CYCLES(TICK_N)) i_dut (
        .clk(clk), .sys_rst(sys_rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ttl_in(ttl_in), .ttl_out(ttl_out), .relay_closed(relay),
        .valve_inject(inject), .zero_pulse(zero), .pump_run(pump),
        .suppressor_run(supp), .aux_supply_on(aux), .mark_active(mark),
        .mark_percent(pct));
    trc_ctrl_model i_ctrl (.clk(clk), .level_req(lvl), .ttl_out(ttl_out),
        .ttl_in(ttl_in), .action_on(act));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One classic cycle; only the slave's ack ends it, and the watchdog
    // catches a slave that never answers.
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic wait_pump(input logic v);
        int n;
        n = 0;
        while (pump !== v && n < 4 * TICK_N) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, pump}, {31'h0, v});
        repeat (MARK_N + 4) @(posedge clk);
    endtask
    // Holds the lines at one level for w ticks, then returns them.
    task automatic pulse(input logic [3:0] on, input logic [3:0] off,
        input int w);
        lvl <= on;
        repeat (w * TICK_N) @(posedge clk);
        lvl <= off;
        repeat (2 * TICK_N) @(posedge clk);
    endtask
    // Read answers are compared against the oldest note in the queue.
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() > 0) begin
                chk(rdat, exp_q.pop_front());
            end else begin
                chk(rdat, rdat === 32'h0 ? 32'h1 : 32'h0);
            end
        end
        if (zero === 1'b1) zero_n++;
        if (mark === 1'b1) mark_n++;
    end
    initial begin
        // The whole run needs about 2650 cycles.
        repeat (10000) @(posedge clk);
        errors++;
        test_done();
    end
    initial begin
        {sys_rst, cyc, stb, we, adr, dat, sel, lvl} = {4'h8, 40'h0, 8'hff};
        {errors, comparisons, zero_n, mark_n} = 128'h0;
        void'($urandom(32'h785836dc));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(trc_pkg::ADDR_CONFIG, 32'h0e4);
        rd(trc_pkg::ADDR_OUTPUT, 32'h3);
        rd(trc_pkg::ADDR_STATUS, 32'h0);
        rd(8'h10, 32'h0);
        chk({30'h0, act}, 32'h0);
        $display("reset test done");
        repeat (4) begin
            r = 4'($urandom);
            bus(trc_pkg::ADDR_OUTPUT, 1'b1, {28'h0, r});
            bus(8'h14, 1'b1, 32'hf);
            rd(trc_pkg::ADDR_OUTPUT, {28'h0, r});
            chk({28'h0, relay, ttl_out}, {28'h0, r});
            chk({30'h0, act}, {30'h0, ~r[1:0]});
        end
        for (int t = 0; t < 4; t++) begin
            m8 = 8'($urandom);
            bus(trc_pkg::ADDR_CONFIG, 1'b1, {22'h0, 2'(t), m8});
            rd(trc_pkg::ADDR_CONFIG, {22'h0, 2'(t), m8});
        end
        bus(trc_pkg::ADDR_CONFIG, 1'b1, 32'h0e4);
        $display("register test done");
        bus(trc_pkg::ADDR_CMD, 1'b1, 32'h2);
        bus(trc_pkg::ADDR_CMD, 1'b1, 32'h8);
        rd(trc_pkg::ADDR_STATUS, 32'h3);
        chk({29'h0, pump, supp, aux}, 32'h7);
        chk({31'h0, inject}, 32'h1);
        bus(trc_pkg::ADDR_CMD, 1'b1, 32'h24);
        chk({24'h0, pct}, {24'h0, trc_pkg::MARK_PERCENT});
        repeat (MARK_N + 4) @(posedge clk);
        chk({24'h0, pct}, 32'h0);
        chk(zero_n, 1);
        chk(mark_n, MARK_N);
        bus(trc_pkg::ADDR_CMD, 1'b1, 32'h11);
        rd(trc_pkg::ADDR_STATUS, 32'h0);
        $display("command test done");
        bus(trc_pkg::ADDR_CMD, 1'b1, 32'h2);
        lvl <= 4'h0;
        wait_pump(1'b1);
        rd(trc_pkg::ADDR_STATUS, 32'h2);
        chk(zero_n, 2);
        chk(mark_n, 2 * MARK_N);
        lvl <= 4'hf;
        wait_pump(1'b0);
        rd(trc_pkg::ADDR_STATUS, 32'h1);
        chk(zero_n, 2);
        chk(mark_n, 2 * MARK_N);
        $display("edge test done");
        bus(trc_pkg::ADDR_CONFIG, 1'b1, 32'h2aa);
        pulse(4'h0, 4'hf, 4);
        chk({31'h0, pump}, 32'h0);
        pulse(4'h0, 4'hf, 50);
        chk({31'h0, pump}, 32'h1);
        bus(trc_pkg::ADDR_CONFIG, 1'b1, 32'h3aa);
        lvl <= 4'h0;
        bus(trc_pkg::ADDR_CMD, 1'b1, 32'h10);
        pulse(4'hf, 4'h0, 4);
        chk({31'h0, pump}, 32'h0);
        pulse(4'hf, 4'h0, 50);
        chk({31'h0, pump}, 32'h1);
        $display("pulse test done");
        test_done();
    end
endmodule
`default_nettype wire
